//--- logic/spm_consts.vh
// constants for the shared pin multiplexer
// assumes plain verilog-2005 includers
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH
`define SPM_PP_WIDTH        16
`define SPM_GROUPS          4
`define SPM_GROUP_SIZE      4
`define SPM_LOW_FLAGS       4
`define SPM_FLAG_CHANNELS   16
`define SPM_RELOC_BASE      8
`define SPM_UPPER_BASE      10
`define SPM_UPPER_COUNT     6
`define SPM_NODE_BASE       25
`define SPM_SYSTEM_CONTROL_REG_PPFS_BIT 20
`define SPM_PARPORT_CONTROL_REG_EN_BIT    0
`define SPM_CAP_SEL_BIT     26
`define SPM_CAP_EN_BIT      31
`define SPM_TMR_PIN         3
`define SPM_MODE_GPIO       2'h0
`define SPM_MODE_IRQ        2'h1
`define SPM_MODE_SPI        2'h2
`define SPM_MODE_SPI_RELOC  2'h3
`define SPM_PP_FN_OFF       3'h0
`define SPM_PP_FN_CAPTURE   3'h1
`define SPM_PP_FN_PORT      3'h2
`define SPM_PP_FN_FLAGS     3'h3
`define SPM_PP_FN_PWM       3'h4
`define SPM_RELOC_GROUP     2'h2
`define SPM_FREE_SPI        12'h00C
`define SPM_FREE_ALL        12'h010
`endif

//--- logic/spm_shared_pin_mux.v
// shared pin multiplexer: low flag pins and parallel-port pins
// assumes control bits come from registers on clk; pin inputs are asynchronous
// outputs follow the controls combinationally; only pin inputs are registered
// relocated low channels sit on port group 2, and also on group 0 when it holds flags
`timescale 1ns/1ps
`include "spm_consts.vh"
module spm_shared_pin_mux #(
	parameter PP_WIDTH = `SPM_PP_WIDTH,
	parameter NFLAGS   = `SPM_FLAG_CHANNELS
) (
	input  wire                clk,                 // peripheral clock, 25 mhz
	input  wire                rst_b,               // chip reset, active low
	input  wire                parport_flag_select, // system control flag select
	input  wire                ext_irq_pin_en,      // interrupt pin enable
	input  wire                timer_expire_pin_en, // timer-expire pin enable
	input  wire                spi_select_pin_en,   // slave select pin enable
	input  wire [3:0]          flag_group_en,       // per-group flag enable
	input  wire [3:0]          pwm_group_en,        // per-group pwm enable (enable index)
	input  wire                parport_en,          // parallel port enable
	input  wire                capture_source_sel,  // capture source select
	input  wire                parallel_capture_en, // parallel capture enable
	input  wire [NFLAGS-1:0]   flag_dir_reg,        // 1 = flag is output
	input  wire [NFLAGS-1:0]   flag_out_val,        // core flag output values
	output reg  [NFLAGS-1:0]   flag_in_val,         // sampled flag values
	input  wire [3:0]          spi_select,          // primary spi slave selects
	input  wire                timer_expire_out,    // core timer expire
	output reg  [2:0]          ext_irq_lines,       // interrupt inputs to core
	input  wire [3:0]          gp_flag_low_in,      // low flag pin inputs
	output reg  [3:0]          gp_flag_low_out,     // low flag pin outputs
	output reg  [3:0]          gp_flag_low_oe,      // low flag pin enables
	input  wire [PP_WIDTH-1:0] pp_port_out,         // parallel port data out
	input  wire [PP_WIDTH-1:0] pp_port_oe,          // parallel port drive enables
	output reg  [PP_WIDTH-1:0] pp_port_in,          // parallel port data in
	input  wire [15:0]         pwm_outputs,         // units 0-3: al,ah,bl,bh each
	input  wire [PP_WIDTH-1:0] parport_addr_data_in,  // port pin inputs
	output reg  [PP_WIDTH-1:0] parport_addr_data_out, // port pin outputs
	output reg  [PP_WIDTH-1:0] parport_addr_data_oe,  // port pin enables
	input  wire [PP_WIDTH-1:0] audio_pin_buffers,   // audio pin inputs (synchronised here)
	output reg  [PP_WIDTH-1:0] capture_data,        // parallel capture inputs
	output reg  [5:0]          route_flag_out,      // upper flags to group d
	output reg  [5:0]          route_flag_pben,     // upper flag enables to group f
	input  wire [5:0]          route_flag_in,       // upper flags from group e
	output reg  [6:0]          audio_internal_nodes, // nodes 25-31 view of upper flags
	output reg  [11:0]         flags_free_count     // general flag channels available
);
	reg  [PP_WIDTH-1:0] pp_s1;
	reg  [PP_WIDTH-1:0] pp_s2;
	reg  [3:0]          low_s1;
	reg  [3:0]          low_s2;
	reg  [PP_WIDTH-1:0] au_s1;
	reg  [PP_WIDTH-1:0] au_s2;
	reg  [1:0]          low_mode;
	reg  [2:0]          pp_fn [0:3];
	reg  [15:0]         flag_src_out;
	reg  [15:0]         flag_src_oe;
	reg                 reloc;
	wire [PP_WIDTH-1:0] pin_drv_val;
	wire [PP_WIDTH-1:0] pin_drv_en;
	wire [PP_WIDTH-1:0] pin_port_in;
	wire [NFLAGS-1:0]   chan_pin_val;
	integer             g;
	genvar              p;
	genvar              c;
	localparam          RELOC_GROUP = `SPM_RELOC_BASE / `SPM_GROUP_SIZE;
	localparam          NGROUPS     = PP_WIDTH / `SPM_GROUP_SIZE;

	// maps group index to the pwm enable bit that owns it
	function [1:0] spm_pwm_enable_of;
		input [1:0] grp;
		begin
			spm_pwm_enable_of = grp ^ 2'h2;
		end
	endfunction

	// flag channel carried by a port pin; relocated low channels sit on group 2
	function [3:0] spm_chan_of;
		input [3:0] pin;
		input       rel;
		begin
			if (rel && pin[3:2] == `SPM_RELOC_GROUP)
				spm_chan_of = {2'h0, pin[1:0]};
			else
				spm_chan_of = pin;
		end
	endfunction

	// true while the slave selects own the low channels
	function spm_mode_is_spi;
		input [1:0] mode;
		begin
			spm_mode_is_spi = (mode == `SPM_MODE_SPI) || (mode == `SPM_MODE_SPI_RELOC);
		end
	endfunction

	// port pin synchroniser
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pp_s1 <= 16'h0000;
			pp_s2 <= 16'h0000;
		end else begin
			pp_s1 <= parport_addr_data_in;
			pp_s2 <= pp_s1;
		end
	end

	// low flag pin synchroniser
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			low_s1 <= 4'h0;
			low_s2 <= 4'h0;
		end else begin
			low_s1 <= gp_flag_low_in;
			low_s2 <= low_s1;
		end
	end

	// audio pin synchroniser
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			au_s1 <= 16'h0000;
			au_s2 <= 16'h0000;
		end else begin
			au_s1 <= audio_pin_buffers;
			au_s2 <= au_s1;
		end
	end

	always @* begin
		if (spi_select_pin_en && !parport_flag_select)
			low_mode = `SPM_MODE_SPI;
		else if (spi_select_pin_en)
			low_mode = `SPM_MODE_SPI_RELOC;
		else if (ext_irq_pin_en || timer_expire_pin_en)
			low_mode = `SPM_MODE_IRQ;
		else
			low_mode = `SPM_MODE_GPIO;
	end

	// low flag channels move to the port when flag select is set and the low pins are not in gpio mode
	always @* begin
		reloc = parport_flag_select && (low_mode != `SPM_MODE_GPIO);
	end

	// per-group function of the port pins
	always @* begin
		for (g = 0; g < NGROUPS; g = g + 1) begin
			if (parallel_capture_en)
				pp_fn[g] = `SPM_PP_FN_CAPTURE;
			else if (parport_en)
				pp_fn[g] = `SPM_PP_FN_PORT;
			else if (parport_flag_select && flag_group_en[g])
				pp_fn[g] = `SPM_PP_FN_FLAGS;
			else if (parport_flag_select && pwm_group_en[spm_pwm_enable_of(g[1:0])])
				pp_fn[g] = `SPM_PP_FN_PWM;
			else
				pp_fn[g] = `SPM_PP_FN_OFF;
		end
	end

	// core-side value and enable of each flag channel
	always @* begin
		flag_src_out = flag_out_val;
		flag_src_oe  = flag_dir_reg;
		// they follow the channels when relocated
		if (spm_mode_is_spi(low_mode)) begin
			flag_src_out[3:0] = spi_select;
			flag_src_oe[3:0]  = 4'hF;
		end
		// twelve channels left while the selects hold four
		flags_free_count = spm_mode_is_spi(low_mode) ? `SPM_FREE_SPI : `SPM_FREE_ALL;
	end

	// low flag pins
	always @* begin
		gp_flag_low_out = 4'h0;
		gp_flag_low_oe  = 4'h0;
		ext_irq_lines   = 3'h0;
		case (low_mode)
			`SPM_MODE_GPIO: begin
				gp_flag_low_out = flag_src_out[3:0];
				gp_flag_low_oe  = flag_src_oe[3:0];
			end
			`SPM_MODE_IRQ: begin
				ext_irq_lines = ext_irq_pin_en ? low_s2[2:0] : 3'h0;
				gp_flag_low_out[`SPM_TMR_PIN] = timer_expire_out;
				gp_flag_low_oe[`SPM_TMR_PIN]  = timer_expire_pin_en;
			end
			`SPM_MODE_SPI: begin
				gp_flag_low_out = spi_select;
				gp_flag_low_oe  = 4'hF;
			end
			`SPM_MODE_SPI_RELOC: begin
				// selects left with the channels, low pins released
				gp_flag_low_out = 4'h0;
				gp_flag_low_oe  = 4'h0;
			end
			default: begin
				gp_flag_low_out = 4'h0;
				gp_flag_low_oe  = 4'h0;
			end
		endcase
	end

	// port pin drive, one pin at a time
	generate
		for (p = 0; p < PP_WIDTH; p = p + 1) begin : g_pin
			localparam [3:0] PIN = p;
			wire [2:0] fn = pp_fn[p / `SPM_GROUP_SIZE];
			// group 2 carries the low channels when relocated
			wire [3:0] ch = spm_chan_of(PIN, reloc);
			// unit g sits on group g; a flag drives port and routing alike
			assign pin_drv_val[p] = (fn == `SPM_PP_FN_PORT)  ? pp_port_out[p] :
				(fn == `SPM_PP_FN_FLAGS) ? flag_src_out[ch] :
				(fn == `SPM_PP_FN_PWM)   ? pwm_outputs[p]   : 1'b0;
			assign pin_drv_en[p]  = (fn == `SPM_PP_FN_PORT)  ? pp_port_oe[p]   :
				(fn == `SPM_PP_FN_FLAGS) ? flag_src_oe[ch]  :
				(fn == `SPM_PP_FN_PWM)   ? 1'b1             : 1'b0;
			assign pin_port_in[p] = (fn == `SPM_PP_FN_PORT) ? pp_s2[p] : 1'b0;
		end
	endgenerate

	// port pin outputs and the parallel port view
	always @* begin
		parport_addr_data_out = pin_drv_val;
		parport_addr_data_oe  = pin_drv_en;
		pp_port_in            = pin_port_in;
	end

	always @* begin
		capture_data = (capture_source_sel && parallel_capture_en) ? pp_s2 : au_s2;
	end

	// value each flag channel reads from its pin
	generate
		for (c = 0; c < NFLAGS; c = c + 1) begin : g_chan
			// a port pin in flag mode wins over low pins and routed inputs
			wire on_port = (pp_fn[c / `SPM_GROUP_SIZE] == `SPM_PP_FN_FLAGS) &&
				!(reloc && (c / `SPM_GROUP_SIZE == RELOC_GROUP));
			if (c < `SPM_LOW_FLAGS) begin : g_low
				wire on_reloc = reloc && (pp_fn[RELOC_GROUP] == `SPM_PP_FN_FLAGS);
				assign chan_pin_val[c] = on_reloc ? pp_s2[c + `SPM_RELOC_BASE] :
					on_port ? pp_s2[c] :
					(low_mode == `SPM_MODE_GPIO) ? low_s2[c] : 1'b0;
			end else if (c >= `SPM_UPPER_BASE) begin : g_up
				// upper channels fall back to the routed input
				assign chan_pin_val[c] = on_port ? pp_s2[c] : route_flag_in[c - `SPM_UPPER_BASE];
			end else begin : g_mid
				// middle channels have no other source
				assign chan_pin_val[c] = on_port ? pp_s2[c] : 1'b0;
			end
		end
	endgenerate

	// outputs echo their value, inputs read their pin
	always @* begin
		flag_in_val = (flag_src_out & flag_src_oe) | (chan_pin_val & ~flag_src_oe);
	end

	// group d and f outputs for upper flags
	always @* begin
		route_flag_out  = flag_src_out[15:10];
		route_flag_pben = flag_src_oe[15:10];
		audio_internal_nodes = {1'b0, flag_in_val[15:10]};
	end
endmodule // spm_shared_pin_mux

//--- test/spm_chk.sv
// checker for the shared pin multiplexer, bound to its top module
// assumes control inputs change only between clock edges
`timescale 1ns/1ps
module spm_chk (
	input wire        clk,                  // clock
	input wire        rst_b,                // reset
	input wire        parallel_capture_en,  // capture on
	input wire        capture_source_sel,   // capture from port
	input wire        parport_en,           // port on
	input wire        parport_flag_select,  // flags to port
	input wire        ext_irq_pin_en,       // irq pins
	input wire        timer_expire_pin_en,  // timer pin
	input wire        spi_select_pin_en,    // selects on low pins
	input wire [3:0]  flag_group_en,        // group flags
	input wire [3:0]  pwm_group_en,         // group pwm
	input wire [15:0] flag_dir_reg,         // flag direction
	input wire [3:0]  spi_select,           // slave selects
	input wire        timer_expire_out,     // timer expire
	input wire [15:0] pwm_outputs,          // pwm units
	input wire [3:0]  gp_flag_low_out,      // low pin value
	input wire [3:0]  gp_flag_low_oe,       // low pin enable
	input wire [15:0] parport_addr_data_in, // port pin in
	input wire [15:0] parport_addr_data_out, // port pin out
	input wire [15:0] parport_addr_data_oe, // port pin enable
	input wire [15:0] capture_data,         // capture view
	input wire [3:0]  gp_flag_low_in,       // low pin level
	input wire [2:0]  ext_irq_lines,        // irq to core
	input wire [15:0] pp_port_in,           // port view
	input wire [11:0] flags_free_count      // free flag channels
);
	wire fl = !parallel_capture_en && !parport_en && parport_flag_select;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_capture_owns_port: assert property (parallel_capture_en |-> parport_addr_data_oe == 16'h0000)
		else $error("capture left port pins driven");
	a_idle_port_hiz: assert property (!parallel_capture_en && !parport_en && !parport_flag_select
		&& pwm_group_en == 4'h0 |-> parport_addr_data_oe == 16'h0000) else $error("idle port pins driven");
	a_spi_low_pins: assert property (spi_select_pin_en && !parport_flag_select
		|-> gp_flag_low_oe == 4'hF && gp_flag_low_out == spi_select) else $error("slave selects wrong");
	a_timer_pin: assert property (ext_irq_pin_en && timer_expire_pin_en && !spi_select_pin_en
		|-> gp_flag_low_oe == 4'h8 && gp_flag_low_out[3] == timer_expire_out) else $error("timer pin wrong");
	a_gpio_low_dir: assert property (!parport_flag_select && !ext_irq_pin_en && !timer_expire_pin_en
		&& !spi_select_pin_en |-> gp_flag_low_oe == flag_dir_reg[3:0]) else $error("low flag dir wrong");
	a_pwm_group_map: assert property (fl && !flag_group_en[0] && pwm_group_en[2]
		|-> parport_addr_data_oe[3:0] == 4'hF && parport_addr_data_out[3:0] == pwm_outputs[3:0])
		else $error("pwm unit 0 map wrong");
	a_flag_over_pwm: assert property (fl && flag_group_en[3] && pwm_group_en[1]
		|-> parport_addr_data_oe[15:12] == flag_dir_reg[15:12]) else $error("pwm beat flags");
	a_free_channels: assert property (!parport_flag_select
		|-> flags_free_count == (spi_select_pin_en ? 12'h00C : 12'h010)) else $error("free count wrong");
	a_capture_source: assert property ((parallel_capture_en && capture_source_sel)[*3] ##0 $past(rst_b, 2)
		|-> capture_data == $past(parport_addr_data_in, 2)) else $error("capture data wrong");
	a_irq_sampled: assert property ((ext_irq_pin_en && !spi_select_pin_en) ##0 $past(rst_b, 2)
		|-> ext_irq_lines == $past(gp_flag_low_in[2:0], 2)) else $error("irq lines wrong");
	a_port_sampled: assert property ((parport_en && !parallel_capture_en) ##0 $past(rst_b, 2)
		|-> pp_port_in == $past(parport_addr_data_in, 2)) else $error("port input wrong");
	c_capture: cover property ((parallel_capture_en && capture_source_sel)[*3]);
	c_pwm: cover property (fl && !flag_group_en[0] && pwm_group_en[2]);
	c_spi: cover property (spi_select_pin_en && !parport_flag_select);
endmodule // spm_chk
bind spm_shared_pin_mux spm_chk u_chk (.*);

//--- test/spm_ext_dev.sv
// outside devices on the low flag and port pins
// assumes they drive every pin the multiplexer has released
`timescale 1ns/1ps
module spm_ext_dev (
	input  wire [19:0] pin_out, // device values
	input  wire [19:0] pin_oe,  // device drives
	input  wire [19:0] ext_val, // outside values
	output wire [19:0] pin_lvl  // wire level
);
	assign pin_lvl = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule // spm_ext_dev

//--- test/tb_top.sv
// random and corner stimulus for the shared pin multiplexer
// assumes the checker is bound in by its own file
`timescale 1ns/1ps
module tb_top;
	reg         clk = 1'b0;
	reg         rst_b = 1'b0;
	reg         parport_flag_select, ext_irq_pin_en, timer_expire_pin_en, spi_select_pin_en, parport_en;
	reg         capture_source_sel, parallel_capture_en, timer_expire_out;
	reg  [3:0]  flag_group_en, pwm_group_en, spi_select;
	reg  [15:0] flag_dir_reg, flag_out_val, pp_port_out, pp_port_oe, pwm_outputs, audio_pin_buffers;
	reg  [5:0]  route_flag_in;
	reg  [19:0] ext_val;
	wire [15:0] flag_in_val, pp_port_in, parport_addr_data_in, parport_addr_data_out, parport_addr_data_oe;
	wire [15:0] capture_data;
	wire [2:0]  ext_irq_lines;
	wire [3:0]  gp_flag_low_in, gp_flag_low_out, gp_flag_low_oe;
	wire [5:0]  route_flag_out, route_flag_pben;
	wire [6:0]  audio_internal_nodes;
	wire [11:0] flags_free_count;
	integer     mismatches = 0, comparisons = 0, cycles = 0, i;
	spm_shared_pin_mux DUT (.*);
	spm_ext_dev u_ext (.pin_out({gp_flag_low_out, parport_addr_data_out}), .pin_oe({gp_flag_low_oe,
		parport_addr_data_oe}), .ext_val(ext_val), .pin_lvl({gp_flag_low_in, parport_addr_data_in}));
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 3000) begin
			mismatches = mismatches + 1;
			finish_test;
		end
	end
	task finish_test;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, mismatches);
			if (mismatches == 0 && comparisons > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	task check(input string nm, input [31:0] e, input [31:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("wrong value %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// expected port pin enables and driven values, from the control bits
	function automatic logic [31:0] exp_pp();
		integer g, k;
		reg [3:0] o, d;
		reg [15:0] so, sd;
		reg reloc;
		begin
			reloc = parport_flag_select && (ext_irq_pin_en || timer_expire_pin_en || spi_select_pin_en);
			so = flag_dir_reg;
			sd = flag_out_val;
			// selects replace the low channels wherever those land
			if (spi_select_pin_en) begin
				so[3:0] = 4'hF;
				sd[3:0] = spi_select;
			end
			exp_pp = {pp_port_oe, pp_port_out & pp_port_oe};
			if (parallel_capture_en)
				exp_pp = 32'h0;
			else if (!parport_en)
				for (g = 0; g < 4; g = g + 1) begin
					o = 4'h0;
					d = 4'h0;
					k = (reloc && g == 2) ? 0 : g;
					if (parport_flag_select && flag_group_en[g]) begin
						o = so[4*k+:4];
						d = sd[4*k+:4];
					end else if (parport_flag_select && pwm_group_en[(g + 2) % 4]) begin
						o = 4'hF;
						d = pwm_outputs[4*g+:4];
					end
					exp_pp[16+4*g+:4] = o;
					exp_pp[4*g+:4] = d & o;
				end
		end
	endfunction
	task rnd;
		begin
			{parport_flag_select, ext_irq_pin_en, timer_expire_pin_en, spi_select_pin_en} = 4'($urandom);
			{parport_en, capture_source_sel, timer_expire_out} = 3'($urandom);
			parallel_capture_en = ($urandom % 8) == 0;
			{flag_group_en, pwm_group_en, spi_select, route_flag_in} = 18'($urandom);
			{flag_dir_reg, flag_out_val} = $urandom;
			{pp_port_out, pp_port_oe} = $urandom;
			{pwm_outputs, audio_pin_buffers} = $urandom;
			ext_val = 20'($urandom);
		end
	endtask
	task cmp;
		begin
			#20;
			check("port pins", exp_pp(), {parport_addr_data_oe, parport_addr_data_out & parport_addr_data_oe});
			if (!parport_flag_select && spi_select_pin_en)
				check("low pins", {4'hF, spi_select}, {gp_flag_low_oe, gp_flag_low_out});
			else if (!spi_select_pin_en && ext_irq_pin_en && timer_expire_pin_en)
				check("low pins", {4'h8, timer_expire_out, 3'h0}, {gp_flag_low_oe, gp_flag_low_out & 4'h8});
			else if (!(parport_flag_select | ext_irq_pin_en | timer_expire_pin_en | spi_select_pin_en))
				check("low pins", {flag_dir_reg[3:0], flag_out_val[3:0] & flag_dir_reg[3:0]},
					{gp_flag_low_oe, gp_flag_low_out & gp_flag_low_oe});
			check("free count", spi_select_pin_en ? 12 : 16, flags_free_count);
			check("route out", {flag_dir_reg[15:10], flag_out_val[15:10]}, {route_flag_pben, route_flag_out});
			check("flag echo", flag_out_val[15:4] & flag_dir_reg[15:4], flag_in_val[15:4] & flag_dir_reg[15:4]);
			if (!parport_flag_select)
				check("nodes", {1'b0, (flag_out_val[15:10] & flag_dir_reg[15:10]) | (route_flag_in & ~flag_dir_reg[15:10])},
					audio_internal_nodes);
		end
	endtask
	initial begin
		void'($urandom(32'hC6FB83F0));
		rnd;
		repeat (16) @(posedge clk);
		#2 rst_b = 1'b1;
		for (i = 0; i < 2040; i = i + 1) begin
			@(posedge clk);
			#2;
			rnd;
			if (i < 4) begin
				{parallel_capture_en, parport_en, parport_flag_select, spi_select_pin_en} = 4'h2;
				flag_group_en = 4'h1 << i;
				pwm_group_en = 4'hF;
			end else if (i < 40) begin
				parallel_capture_en = 1'b1;
				capture_source_sel = 1'b1;
			end
			cmp;
		end
		finish_test;
	end
endmodule // tb_top
